// file: cssel_cfg_if.sv
// Decoded clock configuration passed from the fuse decoder to the top
`timescale 1ns/100ps
interface cssel_cfg_if;
	import cssel_pkg::*;
	logic [3:0]  clock_source_select_fuses;    // Latched source select fuses
	logic [1:0]  startup_time_fuses;      // Latched start-up fuses
	cssel_src_t  src;      // Selected clock source class
	logic [1:0]  range;    // Frequency range within the class
	logic [16:0] wake_len; // Wake-up length in core clocks
	cssel_dly_t  rdly;     // Reset delay class
	logic        sut_rsvd; // Reserved start-up code in use

	modport dec (input clock_source_select_fuses, startup_time_fuses, output src, range, wake_len, rdly, sut_rsvd);
	modport usr (output clock_source_select_fuses, startup_time_fuses, input src, range, wake_len, rdly, sut_rsvd);
endinterface : cssel_cfg_if

// file: cssel_decode.sv
// Fuse decoder: clock source, range, wake length and reset delay class
`timescale 1ns/100ps
`include "cssel_regs.svh"
module cssel_decode
	import cssel_pkg::*;
(
	cssel_cfg_if.dec cfg
);

	// ------------------------------------------------------------------
	// Source decode
	// ------------------------------------------------------------------
	// Pure table lookup; latching of the fuses is done at the top
	always_comb begin
		cfg.range    = cfg.clock_source_select_fuses[1:0] - 2'h1;
		cfg.sut_rsvd = 1'b0;
		cfg.wake_len = `CSSEL_WAKE_FAST;
		cfg.rdly     = CSSEL_DLY_NONE;
		if (cfg.clock_source_select_fuses == `CSSEL_CK_EXT_CLK) begin
			cfg.src = CSSEL_SRC_EXT_CLK;
		end else if (cfg.clock_source_select_fuses <= `CSSEL_CK_IRC_8M) begin
			cfg.src = CSSEL_SRC_INT_RC;
		end else if (cfg.clock_source_select_fuses <= `CSSEL_CK_ERC_HI) begin
			cfg.src   = CSSEL_SRC_EXT_RC;
			cfg.range = cfg.clock_source_select_fuses[1:0] - 2'h1;
		end else begin
			// Crystal and low-frequency paths live elsewhere
			cfg.src   = CSSEL_SRC_OTHER;
			cfg.range = 2'h0;
		end
		// Start-up decode per source class
		if (cfg.src == CSSEL_SRC_EXT_RC) begin
			// Slow RC start needs 18 clocks except the fast option
			cfg.wake_len = (cfg.startup_time_fuses == `CSSEL_SUT_11) ? `CSSEL_WAKE_FAST
			                                          : `CSSEL_WAKE_SLOW;
			case (cfg.startup_time_fuses)
				`CSSEL_SUT_00: cfg.rdly = CSSEL_DLY_NONE;
				`CSSEL_SUT_10: cfg.rdly = CSSEL_DLY_LONG;
				default:       cfg.rdly = CSSEL_DLY_SHORT;
			endcase
		end else if (cfg.src != CSSEL_SRC_OTHER) begin
			cfg.wake_len = `CSSEL_WAKE_FAST;
			case (cfg.startup_time_fuses)
				`CSSEL_SUT_00: cfg.rdly = CSSEL_DLY_NONE;
				`CSSEL_SUT_01: cfg.rdly = CSSEL_DLY_SHORT;
				`CSSEL_SUT_10: cfg.rdly = CSSEL_DLY_LONG;
				default: begin
					// Reserved code: take the longest delay to be safe
					cfg.rdly     = CSSEL_DLY_LONG;
					cfg.sut_rsvd = 1'b1;
				end
			endcase
		end
	end

endmodule : cssel_decode

// file: cssel_delay.sv
// Loadable down counter used for both wake-up and reset delays
`timescale 1ns/100ps
`include "cssel_regs.svh"
module cssel_delay
	import cssel_pkg::*;
(
	input  wire logic        clk_in,    // Core clock
	input  wire logic        reset_in,  // Synchronous reset
	input  wire logic        start_in,  // Start pulse, ignored while running
	input  wire logic        tick_in,   // Count enable
	input  wire logic [16:0] len_in,    // Ticks to wait
	output logic             busy_out,  // Counting
	output logic             done_out   // One-cycle end pulse
);

	cssel_dly_state_t s_q; // Registered state
	cssel_dly_state_t s_d; // Next state

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		case (s_q.st)
			CSSEL_ST_IDLE: begin
				if (start_in) begin
					// Zero length finishes at once
					s_d.cnt = len_in;
					s_d.st  = (len_in == `CSSEL_RDLY_NONE) ? CSSEL_ST_DONE : CSSEL_ST_RUN;
				end
			end
			CSSEL_ST_RUN: begin
				if (tick_in) begin
					s_d.cnt = s_q.cnt - `CSSEL_CNT_ONE;
					if (s_q.cnt == `CSSEL_CNT_ONE) begin
						s_d.st = CSSEL_ST_DONE;
					end
				end
			end
			default: begin
				s_d.st = CSSEL_ST_IDLE;
			end
		endcase
		if (reset_in) begin
			s_d.st  = CSSEL_ST_IDLE;
			s_d.cnt = `CSSEL_RDLY_NONE;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		s_q <= s_d;
	end

	assign busy_out = (s_q.st == CSSEL_ST_RUN);
	assign done_out = (s_q.st == CSSEL_ST_DONE);

endmodule : cssel_delay

// file: cssel_pkg.sv
// Types shared by the clock source select block
package cssel_pkg;

	// ------------------------------------------------------------------
	// Decoded source and reset delay classes
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		CSSEL_SRC_EXT_CLK = 2'h0,
		CSSEL_SRC_INT_RC  = 2'h1,
		CSSEL_SRC_EXT_RC  = 2'h3,
		CSSEL_SRC_OTHER   = 2'h2
	} cssel_src_t;

	typedef enum logic [1:0] {
		CSSEL_DLY_NONE  = 2'h0,
		CSSEL_DLY_SHORT = 2'h1,
		CSSEL_DLY_LONG  = 2'h3
	} cssel_dly_t;

	// Delay counter states, Gray along idle-run-done
	typedef enum logic [1:0] {
		CSSEL_ST_IDLE = 2'h0,
		CSSEL_ST_RUN  = 2'h1,
		CSSEL_ST_DONE = 2'h3
	} cssel_st_t;

	// Delay counter state
	typedef struct packed {
		cssel_st_t   st;
		logic [16:0] cnt;
	} cssel_dly_state_t;

	// Top level state
	typedef struct packed {
		logic        aw_got;
		logic        w_got;
		logic [3:0]  waddr;
		logic [7:0]  wdata;
		logic        wstrb0;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] pin_s1;
		logic [15:0] pin_s2;
		logic        wdt_s1;
		logic        wdt_s2;
		logic        wdt_s3;
		logic [3:0]  clock_source_select_fuses;
		logic [1:0]  startup_time_fuses;
		logic        oscillator_option_fuse;
		logic        legacy;
		logic [7:0]  trim;
		logic        in_rst;
		logic        hold;
	} cssel_state_t;

endpackage : cssel_pkg

// file: cssel_regs.svh
// Register map, fuse codes and timing counts of the clock source select block
`ifndef CSSEL_REGS_SVH
`define CSSEL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CSSEL_ADDR_W         4
`define CSSEL_ADDR_TRIM      4'h0
`define CSSEL_ADDR_STATUS    4'h4

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define CSSEL_RESP_OKAY      2'h0
`define CSSEL_RESP_SLVERR    2'h2
`define CSSEL_ZERO32         32'h0000_0000

// ----------------------------------------------------------------------
// Clock source select codes (programmed fuse reads as zero)
// ----------------------------------------------------------------------
`define CSSEL_CK_EXT_CLK     4'h0
`define CSSEL_CK_IRC_1M      4'h1
`define CSSEL_CK_IRC_8M      4'h4
`define CSSEL_CK_ERC_LO      4'h5
`define CSSEL_CK_ERC_HI      4'h8

// ----------------------------------------------------------------------
// Start-up codes and shipped fuse values
// ----------------------------------------------------------------------
`define CSSEL_SUT_00         2'h0
`define CSSEL_SUT_01         2'h1
`define CSSEL_SUT_10         2'h2
`define CSSEL_SUT_11         2'h3
`define CSSEL_SHIP_CLOCK_SOURCE_SELECT_FUSES     4'h1
`define CSSEL_SHIP_SUT       2'h2

// ----------------------------------------------------------------------
// Delay lengths: wake in core clocks, reset delay in watchdog ticks
// ----------------------------------------------------------------------
`define CSSEL_WAKE_SLOW      17'h0_0012
`define CSSEL_WAKE_FAST      17'h0_0006
`define CSSEL_RDLY_NONE      17'h0_0000
`define CSSEL_RDLY_SHORT     17'h0_1000
`define CSSEL_RDLY_LONG      17'h1_0000
`define CSSEL_CNT_ONE        17'h0_0001

`endif

// file: cssel_top.sv
// Clock source select and oscillator trim with an AXI4-Lite register port
//
// How it works
// - Fuses 0101-1000 select external RC ranges
// - External RC wakes in 18 clocks, 6 for 11
// - External RC reset delay: none, 4.1, 65, 4.1 ms
// - Fuses 0001-0100 select internal RC 1-8 MHz
// - Shipped fuses: internal 1 MHz, start-up code 10
// - Internal RC wakes in 6; delay none/4.1/65
// - Reset copies factory 1 MHz trim byte in
// - Trim zero slowest, larger faster, all-ones fastest
// - Trim 00/7F/FF spans 50-200 percent nominal
// - Reset delay timed by watchdog oscillator ticks
// - Fuses 0000 select external clock on input pin
// - External clock wakes in 6; delay none/4.1/65
// - Trim register absent in legacy compatibility mode
`timescale 1ns/100ps
`include "cssel_regs.svh"
module cssel_top
	import cssel_pkg::*;
#(
	parameter logic [16:0] LONG_DLY_TICKS = `CSSEL_RDLY_LONG // 64K watchdog ticks
)(
	input  wire logic        clk_in,           // Core clock, 100 MHz
	input  wire logic        reset_in,         // Synchronous reset, active high
	input  wire logic [3:0]  clock_source_select_fuses_in, // Raw fuse levels
	input  wire logic [1:0]  startup_time_fuses_in,        // Raw fuse levels
	input  wire logic        oscillator_option_fuse_in,    // Raw fuse level
	input  wire logic        legacy_mode_fuse_in,          // Zero selects legacy mode
	input  wire logic [7:0]  factory_trim_in,  // Signature row byte at 0x00
	input  wire logic        wdt_osc_in,       // Watchdog oscillator pin
	input  wire logic        wake_req_in,      // Wake request pulse
	output logic [1:0]       clk_src_out,      // Selected source class
	output logic [1:0]       freq_range_out,   // Range within the class
	output logic [7:0]       trim_bits_out,    // Trim to the oscillator
	output logic             trim_present_out, // Trim register exists
	output logic             pin_cap_en_out,   // Internal 36 pF on input pin
	output logic             cpu_hold_out,     // Chip held in reset delay
	output logic             wake_busy_out,    // Wake-up count running
	output logic             wake_done_out,    // Wake-up finished pulse
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [3:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	// Power-up contents: synchroniser stages start at the shipped fuse values,
	// so nothing decodes garbage before the first reset has latched the pins
	localparam cssel_state_t PWR_UP = '{
		pin_s1:  {8'h00, 1'b1, 1'b0, `CSSEL_SHIP_SUT, `CSSEL_SHIP_CLOCK_SOURCE_SELECT_FUSES},
		pin_s2:  {8'h00, 1'b1, 1'b0, `CSSEL_SHIP_SUT, `CSSEL_SHIP_CLOCK_SOURCE_SELECT_FUSES},
		default: '0
	};
	cssel_state_t s_q = PWR_UP; // Registered state
	cssel_state_t s_d;          // Next state
	cssel_cfg_if  cfg ();       // Decoded fuse configuration
	logic         wdt_tick;     // One core clock per rising watchdog edge
	logic         rdly_done;    // Reset delay end pulse
	logic         rdly_busy;    // Reset delay counting
	logic         wake_start;   // Accepted wake request
	logic [16:0]  rdly_len;     // Reset delay in watchdog ticks
	logic [15:0]  pin_raw;      // Fuse and factory trim pins gathered
	logic         wr_fire;      // Both write halves held
	logic         legacy;       // Legacy mode active

	// Pins gathered so one two-stage synchroniser covers them all
	assign pin_raw = {factory_trim_in, legacy_mode_fuse_in, oscillator_option_fuse_in,
	                  startup_time_fuses_in, clock_source_select_fuses_in};

	// ------------------------------------------------------------------
	// Fuse decode and delay counters
	// ------------------------------------------------------------------
	assign cfg.clock_source_select_fuses = s_q.clock_source_select_fuses;
	assign cfg.startup_time_fuses   = s_q.startup_time_fuses;

	cssel_decode u_decode (
		.cfg (cfg.dec)
	);

	// Reset delay length chosen from the decoded class
	always_comb begin
		case (cfg.rdly)
			CSSEL_DLY_SHORT: rdly_len = `CSSEL_RDLY_SHORT;
			CSSEL_DLY_LONG:  rdly_len = LONG_DLY_TICKS;
			default:         rdly_len = `CSSEL_RDLY_NONE;
		endcase
	end

	// Watchdog ticks, not the selected clock, time the reset delay
	assign wdt_tick = s_q.wdt_s2 & ~s_q.wdt_s3;

	cssel_delay u_rst_delay (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.start_in (s_q.in_rst),
		.tick_in  (wdt_tick),
		.len_in   (rdly_len),
		.busy_out (rdly_busy),
		.done_out (rdly_done)
	);

	// Wake requests are dropped while held, counting or in the done cycle,
	// since the counter ignores a start while it is leaving its done state
	assign wake_start = wake_req_in & ~s_q.hold & ~wake_busy_out & ~wake_done_out;

	cssel_delay u_wake (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.start_in (wake_start),
		.tick_in  (1'b1),
		.len_in   (cfg.wake_len),
		.busy_out (wake_busy_out),
		.done_out (wake_done_out)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	assign legacy  = s_q.legacy;
	assign wr_fire = s_q.aw_got & s_q.w_got & ~s_q.bvalid;

	always_comb begin
		s_d = s_q;
		// Two-stage synchronisers; stage two is read, and wdt_s3 for the watchdog edge
		s_d.pin_s1 = pin_raw;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.wdt_s1 = wdt_osc_in;
		s_d.wdt_s2 = s_q.wdt_s1;
		s_d.wdt_s3 = s_q.wdt_s2;
		s_d.in_rst = 1'b0;
		// Write address channel
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_got = 1'b1;
			s_d.waddr  = s_axi_awaddr;
		end
		// Write data channel, only byte lane zero carries the trim
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_got  = 1'b1;
			s_d.wdata  = s_axi_wdata[7:0];
			s_d.wstrb0 = s_axi_wstrb[0];
		end
		// Write action once both halves are in
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = `CSSEL_RESP_OKAY;
			if (s_q.waddr == `CSSEL_ADDR_TRIM && !legacy) begin
				// Any value is taken; keeping NVM writes safe is software's job
				if (s_q.wstrb0) begin
					s_d.trim = s_q.wdata;
				end
			end else if (s_q.waddr == `CSSEL_ADDR_STATUS) begin
				// Status is read only, writes are dropped quietly
				s_d.bresp = `CSSEL_RESP_OKAY;
			end else begin
				s_d.bresp = `CSSEL_RESP_SLVERR;
			end
		end else if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		// Read channel
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = `CSSEL_RESP_OKAY;
			if (s_axi_araddr == `CSSEL_ADDR_TRIM && !legacy) begin
				s_d.rdata = {24'h00_0000, s_q.trim};
			end else if (s_axi_araddr == `CSSEL_ADDR_STATUS) begin
				s_d.rdata = {19'h0_0000, wake_busy_out, cfg.sut_rsvd, s_q.hold,
				             cfg.src, s_q.legacy, s_q.oscillator_option_fuse, s_q.startup_time_fuses, s_q.clock_source_select_fuses};
			end else begin
				s_d.rdata = `CSSEL_ZERO32;
				s_d.rresp = `CSSEL_RESP_SLVERR;
			end
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		// Reset delay end releases the hold
		if (rdly_done) begin
			s_d.hold = 1'b0;
		end
		// Synchronous reset: fuses and trim follow the pins while reset is high
		if (reset_in) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b0;
			s_d.rvalid = 1'b0;
			s_d.bresp  = `CSSEL_RESP_OKAY;
			s_d.rresp  = `CSSEL_RESP_OKAY;
			s_d.rdata  = `CSSEL_ZERO32;
			s_d.clock_source_select_fuses  = s_q.pin_s2[3:0];
			s_d.startup_time_fuses    = s_q.pin_s2[5:4];
			s_d.oscillator_option_fuse  = s_q.pin_s2[6];
			s_d.legacy = ~s_q.pin_s2[7];
			s_d.trim   = s_q.pin_s2[15:8];
			s_d.in_rst = 1'b1;
			s_d.hold   = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		s_q <= s_d;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign clk_src_out      = cfg.src;
	assign freq_range_out   = cfg.range;
	assign trim_bits_out    = s_q.trim;
	assign trim_present_out = ~s_q.legacy;
	// Cap on the input pin only for the RC and drive paths
	assign pin_cap_en_out   = ~s_q.oscillator_option_fuse & ((cfg.src == CSSEL_SRC_EXT_RC) |
	                                        (cfg.src == CSSEL_SRC_EXT_CLK));
	assign cpu_hold_out     = s_q.hold;
	assign s_axi_awready    = ~s_q.aw_got & ~s_q.bvalid;
	assign s_axi_wready     = ~s_q.w_got & ~s_q.bvalid;
	assign s_axi_bvalid     = s_q.bvalid;
	assign s_axi_bresp      = s_q.bresp;
	assign s_axi_arready    = ~s_q.rvalid;
	assign s_axi_rvalid     = s_q.rvalid;
	assign s_axi_rdata      = s_q.rdata;
	assign s_axi_rresp      = s_q.rresp;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	property p_erc_src;
		(s_q.clock_source_select_fuses >= `CSSEL_CK_ERC_LO && s_q.clock_source_select_fuses <= `CSSEL_CK_ERC_HI)
		|-> clk_src_out == CSSEL_SRC_EXT_RC && freq_range_out == s_q.clock_source_select_fuses[1:0] - 2'h1;
	endproperty
	a_erc_src: assert property (p_erc_src) else $error("ext RC decode");

	property p_erc_wake;
		(cfg.src == CSSEL_SRC_EXT_RC && s_q.startup_time_fuses != `CSSEL_SUT_11)
		|-> cfg.wake_len == `CSSEL_WAKE_SLOW;
	endproperty
	a_erc_wake: assert property (p_erc_wake) else $error("ext RC wake length");

	property p_erc_rdly;
		(cfg.src == CSSEL_SRC_EXT_RC && s_q.startup_time_fuses == `CSSEL_SUT_11)
		|-> cfg.rdly == CSSEL_DLY_SHORT && cfg.wake_len == `CSSEL_WAKE_FAST;
	endproperty
	a_erc_rdly: assert property (p_erc_rdly) else $error("ext RC fast code");

	property p_irc_src;
		(s_q.clock_source_select_fuses != `CSSEL_CK_EXT_CLK && s_q.clock_source_select_fuses <= `CSSEL_CK_IRC_8M)
		|-> clk_src_out == CSSEL_SRC_INT_RC;
	endproperty
	a_irc_src: assert property (p_irc_src) else $error("int RC decode");

	property p_trim_load;
		$fell(reset_in) |-> trim_bits_out == $past(s_q.pin_s2[15:8]);
	endproperty
	a_trim_load: assert property (p_trim_load) else $error("trim not loaded");

	property p_wake6;
		(wake_start && cfg.wake_len == `CSSEL_WAKE_FAST)
		|=> wake_busy_out [*6] ##1 wake_done_out;
	endproperty
	a_wake6: assert property (p_wake6) else $error("6 clock wake");

	property p_extclk;
		s_q.clock_source_select_fuses == `CSSEL_CK_EXT_CLK |-> clk_src_out == CSSEL_SRC_EXT_CLK
		&& cfg.wake_len == `CSSEL_WAKE_FAST;
	endproperty
	a_extclk: assert property (p_extclk) else $error("ext clock decode");

	property p_legacy;
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == `CSSEL_ADDR_TRIM && legacy)
		|=> s_axi_rvalid && s_axi_rresp == `CSSEL_RESP_SLVERR;
	endproperty
	a_legacy: assert property (p_legacy) else $error("trim seen in legacy");

	property p_wr_trim;
		(wr_fire && s_q.waddr == `CSSEL_ADDR_TRIM && s_q.wstrb0 && !legacy)
		|=> trim_bits_out == $past(s_q.wdata) && s_axi_bvalid;
	endproperty
	a_wr_trim: assert property (p_wr_trim) else $error("trim write lost");

	property p_rdly_none;
		// The flag is still seen on the release edge, so allow one edge more
		(s_q.in_rst && rdly_len == `CSSEL_RDLY_NONE) |-> ##3 !cpu_hold_out;
	endproperty
	a_rdly_none: assert property (p_rdly_none) else $error("zero delay held");

	c_wake:  cover property (wake_start ##[1:20] wake_done_out);
	c_write: cover property (wr_fire && s_q.waddr == `CSSEL_ADDR_TRIM);
	c_rdone: cover property (rdly_done);
	c_erc:   cover property (clk_src_out == CSSEL_SRC_EXT_RC && wake_done_out);

endmodule : cssel_top

// file: cssel_top_bench.sv
// Self-checking bench for the clock source select and trim block
`timescale 1ns/100ps
`include "cssel_regs.svh"
module cssel_top_bench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam int LD = 16; // Shortened long reset delay, in ticks
	typedef struct {
		logic [3:0] ck;
		logic [1:0] startup_time_fuses;
		logic       opt, leg;
		logic [1:0] src, rng;
		logic       cap;
		int         wk, dly;
	} cssel_row_t;
	logic        clk_in = 1'b0, reset_in = 1'b1, opt = 1'b1, leg = 1'b1, wake = 1'b0;
	logic [3:0]  ck = 4'h1, awa = 4'h0, ara = 4'h0, strb = 4'hF;
	logic [1:0]  startup_time_fuses = 2'h0, src, rng, bresp, rresp;
	logic [7:0]  ftrim = 8'h00, trim;
	logic        wdt, present, cap, hold, busy, done;
	logic        awv = 1'b0, awr, wv = 1'b0, wrdy, bv, br = 1'b0;
	logic        arv = 1'b0, arr, rv, rr = 1'b0;
	logic [31:0] wd = 32'h0000_0000, rd;
	int          num_errors = 0, compares = 0;
	// Fuse settings beside the outputs they should give
	cssel_row_t rows [12] = '{
		'{4'h0, 2'h0, 1'b0, 1'b1, 2'h0, 2'h0, 1'b1, 6, 0},
		'{4'h1, 2'h2, 1'b1, 1'b1, 2'h1, 2'h0, 1'b0, 6, LD},
		'{4'h2, 2'h0, 1'b1, 1'b1, 2'h1, 2'h1, 1'b0, 6, 0},
		'{4'h3, 2'h1, 1'b1, 1'b1, 2'h1, 2'h2, 1'b0, 6, 4096},
		'{4'h4, 2'h0, 1'b1, 1'b1, 2'h1, 2'h3, 1'b0, 6, 0},
		'{4'h5, 2'h0, 1'b0, 1'b1, 2'h3, 2'h0, 1'b1, 18, 0},
		'{4'h6, 2'h1, 1'b1, 1'b1, 2'h3, 2'h1, 1'b0, 18, 4096},
		'{4'h7, 2'h2, 1'b1, 1'b1, 2'h3, 2'h2, 1'b0, 18, LD},
		'{4'h8, 2'h3, 1'b0, 1'b1, 2'h3, 2'h3, 1'b1, 6, 4096},
		'{4'h9, 2'h0, 1'b1, 1'b1, 2'h2, 2'h0, 1'b0, 6, 0},
		'{4'h2, 2'h3, 1'b1, 1'b1, 2'h1, 2'h1, 1'b0, 6, LD},
		'{4'h0, 2'h2, 1'b1, 1'b0, 2'h0, 2'h0, 1'b0, 6, LD}
	};
	logic [7:0]  tv [3] = '{8'h00, 8'h7F, 8'hFF};

	// ------------------------------------------------------------
	// Instances and clock
	// ------------------------------------------------------------
	always #5 clk_in = ~clk_in;
	cssel_wdt_model cssel_wdt_model_inst (.wdt_osc_out(wdt));
	cssel_top #(.LONG_DLY_TICKS(17'(LD))) cssel_top_inst (
		.clk_in(clk_in), .reset_in(reset_in), .clock_source_select_fuses_in(ck),
		.startup_time_fuses_in(startup_time_fuses), .oscillator_option_fuse_in(opt),
		.legacy_mode_fuse_in(leg), .factory_trim_in(ftrim), .wdt_osc_in(wdt),
		.wake_req_in(wake), .clk_src_out(src), .freq_range_out(rng),
		.trim_bits_out(trim), .trim_present_out(present), .pin_cap_en_out(cap),
		.cpu_hold_out(hold), .wake_busy_out(busy), .wake_done_out(done),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(strb),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task chk_resp(input logic [1:0] got, input logic [1:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t response %h expected %h", $time, got, exp);
		end
	endtask : chk_resp
	// Fuses must settle before reset: they are latched only while it is high
	task boot(input cssel_row_t r, input logic [7:0] t, output int ticks);
		int   n;
		logic pw;
		ck <= r.ck;
		startup_time_fuses <= r.startup_time_fuses;
		opt <= r.opt;
		leg <= r.leg;
		ftrim <= t;
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		ticks = 0;
		pw = wdt;
		for (n = 0; n < 20000 && hold !== 1'b0; n++) begin
			@(posedge clk_in);
			ticks += int'(wdt && !pw);
			pw = wdt;
		end
	endtask : boot
	task wake_len(output int n);
		int k;
		@(posedge clk_in);
		wake <= 1'b1;
		@(posedge clk_in);
		wake <= 1'b0;
		n = 0;
		for (k = 0; k < 40; k++) begin
			#1;
			if (done === 1'b1) break;
			n += int'(busy === 1'b1);
			@(posedge clk_in);
		end
	endtask : wake_len
	task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		r = 'x;
		@(posedge clk_in);
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		strb <= s;
		br <= 1'b1;
		// Waits as long as it takes; only the bench watchdog ends a hang
		do begin
			@(posedge clk_in);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
		end while (bv !== 1'b1);
		r = bresp;
		br <= 1'b0;
	endtask : axi_wr
	task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		d = 'x;
		r = 'x;
		@(posedge clk_in);
		arv <= 1'b1;
		ara <= a;
		rr <= 1'b1;
		do begin
			@(posedge clk_in);
			if (arv && arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rd;
		r = rresp;
		rr <= 1'b0;
	endtask : axi_rd
	task summarize;
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : summarize

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		int          i, j, n, tk;
		logic [31:0] d;
		logic [1:0]  r;
		for (i = 0; i < 12; i++) begin
			boot(rows[i], 8'h3C ^ 8'(i), tk);
			chk_val(tk >= rows[i].dly - 1 && tk <= rows[i].dly + 2, 1);
			chk_val(src, rows[i].src);
			if (rows[i].src !== 2'h0) chk_val(rng, rows[i].rng);
			chk_val(cap, rows[i].cap);
			chk_val(present, rows[i].leg);
			if (rows[i].leg) chk_val(trim, 8'h3C ^ 8'(i));
			wake_len(n);
			chk_val(n, rows[i].wk);
			chk_val(done, 1);
		end
		axi_rd(`CSSEL_ADDR_TRIM, d, r);
		chk_resp(r, `CSSEL_RESP_SLVERR);
		boot(rows[2], 8'hA5, tk);
		axi_rd(`CSSEL_ADDR_TRIM, d, r);
		chk_val(d, 32'h0000_00A5);
		// Software loads its own trim, 00, 7F and FF in turn, each read back
		foreach (tv[j]) begin
			axi_wr(`CSSEL_ADDR_TRIM, {24'h00_0000, tv[j]}, 4'h1, r);
			chk_resp(r, `CSSEL_RESP_OKAY);
			chk_val(trim, tv[j]);
			axi_rd(`CSSEL_ADDR_TRIM, d, r);
			chk_val(d, {24'h00_0000, tv[j]});
		end
		axi_wr(`CSSEL_ADDR_TRIM, 32'h0000_0011, 4'hE, r);
		chk_val(trim, 8'hFF);
		axi_rd(`CSSEL_ADDR_STATUS, d, r);
		chk_val(d[6:0], 7'h42);
		chk_val(d[10:8], 3'h1);
		axi_rd(4'h8, d, r);
		chk_resp(r, `CSSEL_RESP_SLVERR);
		axi_wr(4'hC, 32'h0000_0033, 4'hF, r);
		chk_resp(r, `CSSEL_RESP_SLVERR);
		chk_val(trim, 8'hFF);
		summarize();
	end
	// Hang guard: about eight tenths of a millisecond covers every delay
	initial begin
		#800000;
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
endmodule : cssel_top_bench

// file: cssel_wdt_model.sv
// Free-running watchdog oscillator model facing the clock source select block
`timescale 1ns/100ps
module cssel_wdt_model #(
	parameter int HALF_NS = 20 // Half period, one tick per four core clocks
)(
	output logic wdt_osc_out // Oscillator level
);
	// ------------------------------------------------------------
	// Oscillator
	// ------------------------------------------------------------
	// Fixed period: no cycle-to-cycle drift at all, never needs a reset
	initial begin
		wdt_osc_out = 1'b0;
		#3; // Phase unrelated to the core clock
		forever #(HALF_NS) wdt_osc_out = ~wdt_osc_out;
	end
endmodule : cssel_wdt_model
